// File: ciecd_pkg.sv
package ciecd_pkg;

    // ==================================================================
    // widths
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int PC_W      = 15;
    localparam int UPC_W     = 7;
    localparam int FA_W      = 7;
    localparam int FILE_DEPTH = 128;
    localparam int STK_DEPTH = 16;
    localparam int STK_PTR_W = 4;
    localparam int WDOG_W    = 8;
    localparam int PRESC_W   = 8;
    localparam int CMD_W     = 11;

    // ==================================================================
    // register byte offsets
    localparam logic [11:0] OFF_CMD    = 12'h000;
    localparam logic [11:0] OFF_ACC    = 12'h004;
    localparam logic [11:0] OFF_PC     = 12'h008;
    localparam logic [11:0] OFF_UPC    = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_WDOG   = 12'h014;
    localparam logic [11:0] OFF_PRESC  = 12'h018;
    localparam logic [11:0] OFF_STACK  = 12'h01c;
    // file window: 128 words from 0x200
    localparam logic [2:0]  FILE_SEL   = 3'h1;
    localparam int          FILE_SEL_LSB = 9;
    localparam int          FILE_IDX_LSB = 2;

    // ==================================================================
    // status field positions and reset values
    localparam int ST_Z_BIT    = 0;
    localparam int ST_SLEEP_BIT = 1;
    localparam int ST_TO_BIT   = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam logic RST_Z  = 1'b0;
    localparam logic RST_SLEEP = 1'b1;
    localparam logic RST_TO = 1'b1;
    localparam logic [PC_W-1:0]  RST_PC  = 15'h0000;
    localparam logic [7:0]       RST_ACC = 8'h00;
    localparam logic [UPC_W-1:0] RST_UPC = 7'h00;
    localparam logic [7:0]       ZERO8   = 8'h00;

    // ==================================================================
    // command encoding: {faddr[10:4], dest[3], op[2:0]}
    typedef enum logic [2:0] {
        OP_NOP      = 3'b000,
        OP_KICK     = 3'b001,
        OP_ICALL    = 3'b010,
        OP_INVERT   = 3'b011,
        OP_ZREG     = 3'b100,
        OP_ZACC     = 3'b101,
        OP_DEC      = 3'b110,
        OP_DECSKIP  = 3'b111
    } ciecd_op_t;

    typedef struct packed {
        logic [FA_W-1:0] faddr;
        logic            dest;
        ciecd_op_t       op;
    } ciecd_cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic       zero;
    } ciecd_alu_out_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC1 = 2'b01,
        ST_EXEC2 = 2'b10
    } ciecd_state_t;

endpackage : ciecd_pkg

// File: ciecd_alu.sv
`timescale 1ns/1ps
module ciecd_alu (
    input  wire ciecd_pkg::ciecd_op_t      op,
    input  wire logic [7:0]                operand,
    output ciecd_pkg::ciecd_alu_out_t      result
);

    // ==================================================================
    // result per operation
    logic [7:0] res;

    always_comb begin
        case (op)
            ciecd_pkg::OP_INVERT:  res = ~operand;
            ciecd_pkg::OP_DEC:     res = operand - 8'h01;
            ciecd_pkg::OP_DECSKIP: res = operand - 8'h01;
            ciecd_pkg::OP_ZREG:    res = ciecd_pkg::ZERO8;
            ciecd_pkg::OP_ZACC:    res = ciecd_pkg::ZERO8;
            default:               res = operand;
        endcase
    end

    assign result.res  = res;
    assign result.zero = (res == ciecd_pkg::ZERO8);

endmodule : ciecd_alu

// File: ciecd_exec.sv
// Behaviour
// - kick zeroes watchdog counter and prescaler
// - kick sets expiry and sleep-entry bits
// - indirect call pushes pc plus one
// - then pc gets upper holding and accumulator
// - indirect call: two cycles, flags untouched
// - invert register, destination bit, zero flag
// - zero register, always set zero flag
// - zero accumulator, always set zero flag
// - decrement register, destination bit, zero flag
// - decrement, skip on zero, flags untouched
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ciecd_exec (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ==================================================================
    // state
    ciecd_pkg::ciecd_state_t   state, next_state;
    ciecd_pkg::ciecd_cmd_t     cmd, next_cmd;
    logic [7:0]                acc, next_acc;
    logic [14:0]               pc, next_pc;
    logic [6:0]                upc, next_upc;
    logic                      z, next_z;
    logic                      sleep_entry_flag, next_sleep_entry_flag;
    logic                      to, next_to;
    logic [7:0]                watchdog_counter, next_watchdog_counter;
    logic [7:0]                presc, next_presc;
    logic [3:0]                sp, next_sp;
    logic [31:0]               next_prdata;
    logic                      prev_idle;
    logic [7:0]                file_mem [ciecd_pkg::FILE_DEPTH];
    logic [14:0]               stack_mem [ciecd_pkg::STK_DEPTH];
    logic                      mem_we;
    logic [6:0]                mem_wa;
    logic [7:0]                mem_wd;
    logic                      stk_we;
    logic [14:0]               stk_wd;
    logic [7:0]                file_rd;
    logic [14:0]               stack_top;
    logic                      idle;
    logic                      apb_wr;
    ciecd_pkg::ciecd_alu_out_t alu;

    // ==================================================================
    // address decode
    function automatic logic is_file(input logic [11:0] a);
        is_file = (a[11:ciecd_pkg::FILE_SEL_LSB] == ciecd_pkg::FILE_SEL)
                  && (a[1:0] == 2'h0);
    endfunction : is_file

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_file(a) || (a == ciecd_pkg::OFF_CMD)
                    || (a == ciecd_pkg::OFF_ACC) || (a == ciecd_pkg::OFF_PC)
                    || (a == ciecd_pkg::OFF_UPC)
                    || (a == ciecd_pkg::OFF_STATUS)
                    || (a == ciecd_pkg::OFF_WDOG)
                    || (a == ciecd_pkg::OFF_PRESC)
                    || (a == ciecd_pkg::OFF_STACK);
    endfunction : is_mapped

    // ==================================================================
    // apb handshake
    // prdata is captured a cycle early, so only answer once idle twice
    assign idle    = (state == ciecd_pkg::ST_IDLE);
    assign pready  = idle && prev_idle;
    assign pslverr = pready && psel && penable && !is_mapped(paddr);
    assign apb_wr  = pready && psel && penable && pwrite;

    assign file_rd   = file_mem[cmd.faddr];
    assign stack_top = stack_mem[sp - 4'h1];

    ciecd_alu u_alu (
        .op      (cmd.op),
        .operand (file_rd),
        .result  (alu)
    );

    // ==================================================================
    // read mux
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (is_file(paddr)) begin
            next_prdata[7:0] =
                file_mem[paddr[ciecd_pkg::FILE_IDX_LSB +: 7]];
        end else if (paddr == ciecd_pkg::OFF_CMD) begin
            next_prdata[10:0] = cmd;
        end else if (paddr == ciecd_pkg::OFF_ACC) begin
            next_prdata[7:0] = acc;
        end else if (paddr == ciecd_pkg::OFF_PC) begin
            next_prdata[14:0] = pc;
        end else if (paddr == ciecd_pkg::OFF_UPC) begin
            next_prdata[6:0] = upc;
        end else if (paddr == ciecd_pkg::OFF_STATUS) begin
            next_prdata[ciecd_pkg::ST_Z_BIT]    = z;
            next_prdata[ciecd_pkg::ST_SLEEP_BIT] = sleep_entry_flag;
            next_prdata[ciecd_pkg::ST_TO_BIT]   = to;
            next_prdata[ciecd_pkg::ST_BUSY_BIT] = !idle;
        end else if (paddr == ciecd_pkg::OFF_WDOG) begin
            next_prdata[7:0] = watchdog_counter;
        end else if (paddr == ciecd_pkg::OFF_PRESC) begin
            next_prdata[7:0] = presc;
        end else if (paddr == ciecd_pkg::OFF_STACK) begin
            next_prdata[14:0] = stack_top;
        end
    end

    // ==================================================================
    // execution next state
    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        next_acc   = acc;
        next_pc    = pc;
        next_upc   = upc;
        next_z     = z;
        next_sleep_entry_flag = sleep_entry_flag;
        next_to    = to;
        next_sp    = sp;
        mem_we     = 1'b0;
        mem_wa     = cmd.faddr;
        mem_wd     = alu.res;
        stk_we     = 1'b0;
        stk_wd     = pc + 15'h0001;
        // free-running stand-in; timeout logic lives elsewhere
        next_presc = presc + 8'h01;
        next_watchdog_counter = (presc == 8'hff)
                                ? watchdog_counter + 8'h01
                                : watchdog_counter;
        case (state)
            ciecd_pkg::ST_IDLE: begin
                if (apb_wr) begin
                    if (is_file(paddr)) begin
                        mem_we = 1'b1;
                        mem_wa = paddr[ciecd_pkg::FILE_IDX_LSB +: 7];
                        mem_wd = pwdata[7:0];
                    end else if (paddr == ciecd_pkg::OFF_CMD) begin
                        next_cmd   = pwdata[10:0];
                        next_state = ciecd_pkg::ST_EXEC1;
                    end else if (paddr == ciecd_pkg::OFF_ACC) begin
                        next_acc = pwdata[7:0];
                    end else if (paddr == ciecd_pkg::OFF_PC) begin
                        next_pc = pwdata[14:0];
                    end else if (paddr == ciecd_pkg::OFF_UPC) begin
                        next_upc = pwdata[6:0];
                    end else if (paddr == ciecd_pkg::OFF_STATUS) begin
                        next_z  = pwdata[ciecd_pkg::ST_Z_BIT];
                        next_sleep_entry_flag =
                            pwdata[ciecd_pkg::ST_SLEEP_BIT];
                        next_to = pwdata[ciecd_pkg::ST_TO_BIT];
                    end
                end
            end
            ciecd_pkg::ST_EXEC1: begin
                next_state = ciecd_pkg::ST_IDLE;
                next_pc    = pc + 15'h0001;
                case (cmd.op)
                    ciecd_pkg::OP_KICK: begin
                        next_watchdog_counter = ciecd_pkg::ZERO8;
                        next_presc = ciecd_pkg::ZERO8;
                        next_to = 1'b1;
                        next_sleep_entry_flag = 1'b1;
                    end
                    ciecd_pkg::OP_ICALL: begin
                        stk_we     = 1'b1;
                        next_sp    = sp + 4'h1;
                        next_pc    = pc;
                        next_state = ciecd_pkg::ST_EXEC2;
                    end
                    ciecd_pkg::OP_INVERT, ciecd_pkg::OP_DEC: begin
                        if (cmd.dest) begin
                            mem_we = 1'b1;
                        end else begin
                            next_acc = alu.res;
                        end
                        next_z = alu.zero;
                    end
                    ciecd_pkg::OP_ZREG: begin
                        mem_we = 1'b1;
                        next_z = 1'b1;
                    end
                    ciecd_pkg::OP_ZACC: begin
                        next_acc = ciecd_pkg::ZERO8;
                        next_z   = 1'b1;
                    end
                    ciecd_pkg::OP_DECSKIP: begin
                        // store, no flags, skip on zero
                        if (cmd.dest) begin
                            mem_we = 1'b1;
                        end else begin
                            next_acc = alu.res;
                        end
                        if (alu.zero) begin
                            next_state = ciecd_pkg::ST_EXEC2;
                        end
                    end
                    default: begin
                        next_pc = pc + 15'h0001;
                    end
                endcase
            end
            ciecd_pkg::ST_EXEC2: begin
                next_state = ciecd_pkg::ST_IDLE;
                if (cmd.op == ciecd_pkg::OP_ICALL) begin
                    next_pc = {upc, acc};
                end else begin
                    // discarded word runs as a no-op
                    next_pc = pc + 15'h0001;
                end
            end
            default: begin
                next_state = ciecd_pkg::ST_IDLE;
            end
        endcase
    end

    // ==================================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ciecd_pkg::ST_IDLE;
            cmd       <= '0;
            acc       <= ciecd_pkg::RST_ACC;
            pc        <= ciecd_pkg::RST_PC;
            upc       <= ciecd_pkg::RST_UPC;
            z         <= ciecd_pkg::RST_Z;
            sleep_entry_flag <= ciecd_pkg::RST_SLEEP;
            to        <= ciecd_pkg::RST_TO;
            watchdog_counter <= ciecd_pkg::ZERO8;
            presc     <= ciecd_pkg::ZERO8;
            sp        <= 4'h0;
            prdata    <= 32'h0000_0000;
            prev_idle <= 1'b0;
        end else begin
            state     <= next_state;
            cmd       <= next_cmd;
            acc       <= next_acc;
            pc        <= next_pc;
            upc       <= next_upc;
            z         <= next_z;
            sleep_entry_flag <= next_sleep_entry_flag;
            to        <= next_to;
            watchdog_counter <= next_watchdog_counter;
            presc     <= next_presc;
            sp        <= next_sp;
            prdata    <= next_prdata;
            prev_idle <= idle;
        end
    end

    // stack wraps at sixteen entries, deepest entry is overwritten
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            file_mem[mem_wa] <= mem_wd;
        end
        if (stk_we) begin
            stack_mem[sp] <= stk_wd;
        end
    end

    // ==================================================================
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic ex1;
    assign ex1 = (state == ciecd_pkg::ST_EXEC1);

    a_kick_count_zero: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_KICK
            |=> watchdog_counter == 8'h00
            && presc == 8'h00 ##1 presc == 8'h01)
        else $error("kick did not restart watchdog");

    a_kick_flags_set: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_KICK |=> to && sleep_entry_flag)
        else $error("kick did not set status bits");

    a_call_push_ret: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_ICALL
            |=> stack_top == $past(pc) + 15'h0001
                && sp == $past(sp) + 4'h1)
        else $error("call pushed wrong return address");

    a_call_pc_load: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_ICALL
            |=> ##1 pc == {$past(upc, 2), $past(acc, 2)})
        else $error("call loaded wrong pc");

    a_call_two_cyc: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_ICALL
            |=> state == ciecd_pkg::ST_EXEC2 ##1 idle
                && z == $past(z, 2) && to == $past(to, 2)
                && sleep_entry_flag == $past(sleep_entry_flag, 2))
        else $error("call timing or flags wrong");

    a_invert_acc: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_INVERT && !cmd.dest
            |=> acc == ~$past(file_rd))
        else $error("invert result wrong");

    a_zero_reg_set: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_ZREG
            |=> z && file_mem[$past(cmd.faddr)] == 8'h00)
        else $error("register clear failed");

    a_zero_acc_set: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_ZACC |=> z && acc == 8'h00)
        else $error("accumulator clear failed");

    a_dec_acc_res: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_DEC && !cmd.dest
            |=> acc == $past(file_rd) - 8'h01)
        else $error("decrement result wrong");

    a_skip_pc_two: assert property (
        ex1 && cmd.op == ciecd_pkg::OP_DECSKIP && alu.zero
            |=> state == ciecd_pkg::ST_EXEC2 ##1 idle
                && pc == $past(pc, 2) + 15'h0002 && z == $past(z, 2))
        else $error("skip did not discard next word");

    a_zero_flag_res: assert property (
        ex1 && (cmd.op == ciecd_pkg::OP_INVERT
                || cmd.op == ciecd_pkg::OP_DEC)
            |=> z == ($past(alu.res) == 8'h00))
        else $error("zero flag mismatch");

    c_call_done: cover property (
        ex1 && cmd.op == ciecd_pkg::OP_ICALL ##2 idle);
    c_skip_taken: cover property (
        ex1 && cmd.op == ciecd_pkg::OP_DECSKIP && alu.zero);
    c_kick_run: cover property (ex1 && cmd.op == ciecd_pkg::OP_KICK);
    c_invert_file: cover property (
        ex1 && cmd.op == ciecd_pkg::OP_INVERT && cmd.dest);

endmodule : ciecd_exec

// File: ciecd_exec_tb.sv
`timescale 1ns/1ps
module ciecd_exec_tb;

    // ==================================================================
    // bench signals
    logic        core_clk  = 1'h0;
    logic        rst_n     = 1'h0;
    logic        psel      = 1'h0;
    logic        penable   = 1'h0;
    logic        pwrite    = 1'h0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          err_count = 0;
    int          checked   = 0;
    int          waits;
    logic [31:0] rd;
    logic        er;

    typedef struct {
        ciecd_pkg::ciecd_op_t op;
        logic                 dest;
        logic [6:0]           fa;
        logic [7:0]           fval;
        logic [7:0]           res;
        logic                 zpre;
        logic                 zexp;
        logic [1:0]           pcinc;
    } ciecd_row_t;

    ciecd_row_t r;
    // pcinc doubles as the expected count of access-phase samples
    ciecd_row_t rows [8] = '{
        '{ciecd_pkg::OP_INVERT,  1'h0, 7'h00, 8'hff, 8'h00, 1'h0, 1'h1, 2'h1},
        '{ciecd_pkg::OP_INVERT,  1'h1, 7'h7f, 8'h5a, 8'ha5, 1'h1, 1'h0, 2'h1},
        '{ciecd_pkg::OP_ZREG,    1'h1, 7'h03, 8'h77, 8'h00, 1'h0, 1'h1, 2'h1},
        '{ciecd_pkg::OP_ZACC,    1'h0, 7'h05, 8'h11, 8'h00, 1'h0, 1'h1, 2'h1},
        '{ciecd_pkg::OP_DEC,     1'h0, 7'h0a, 8'h01, 8'h00, 1'h0, 1'h1, 2'h1},
        '{ciecd_pkg::OP_DEC,     1'h1, 7'h40, 8'h00, 8'hff, 1'h1, 1'h0, 2'h1},
        '{ciecd_pkg::OP_DECSKIP, 1'h1, 7'h14, 8'h01, 8'h00, 1'h0, 1'h0, 2'h2},
        '{ciecd_pkg::OP_DECSKIP, 1'h0, 7'h15, 8'h02, 8'h01, 1'h1, 1'h1, 2'h1}
    };

    ciecd_exec u_ciecd_exec (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr)
    );

    always #12.5 core_clk = ~core_clk;

    // ==================================================================
    // bus and check tasks
    function automatic logic [11:0] fadr(input logic [6:0] fa);
        return {ciecd_pkg::FILE_SEL, fa, 2'h0};
    endfunction : fadr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask : chk

    // pready polled at every access-phase rising edge; data and error taken at the accepting edge only
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        waits = 0;
        do begin
            @(posedge core_clk);
            waits++;
        end while (pready !== 1'h1 && waits < 20);
        if (pready !== 1'h1) begin
            chk(32'h0, 32'h1, "pready never came");
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                       input string m);
        xfer(1'h0, a, 32'h0);
        chk(rd, exp, m);
    endtask : rdc

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // ==================================================================
    // watchdog: the whole run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_sim();
    end

    // ==================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        rdc(ciecd_pkg::OFF_ACC, 32'h0, "acc reset");
        rdc(ciecd_pkg::OFF_PC, 32'h0, "pc reset");
        rdc(ciecd_pkg::OFF_STATUS, 32'h6, "status reset");
        foreach (rows[i]) begin
            r = rows[i];
            wr(fadr(r.fa), {24'h0, r.fval});
            wr(ciecd_pkg::OFF_ACC, 32'h5a);
            wr(ciecd_pkg::OFF_PC, 32'h100);
            wr(ciecd_pkg::OFF_STATUS, {28'h0, 3'h3, r.zpre});
            wr(ciecd_pkg::OFF_CMD, {21'h0, r.fa, r.dest, r.op});
            xfer(1'h0, r.dest ? fadr(r.fa) : ciecd_pkg::OFF_ACC, 32'h0);
            chk(32'(waits), {30'h0, r.pcinc}, "op cycles");
            chk(rd, {24'h0, r.res}, "result");
            rdc(r.dest ? ciecd_pkg::OFF_ACC : fadr(r.fa),
                r.dest ? 32'h5a : {24'h0, r.fval}, "untouched");
            rdc(ciecd_pkg::OFF_STATUS, {28'h0, 3'h3, r.zexp}, "z");
            rdc(ciecd_pkg::OFF_PC, 32'h100 + r.pcinc, "pc step");
        end
        // watchdog kick after the counter has had time to move
        repeat (600) @(posedge core_clk);
        xfer(1'h0, ciecd_pkg::OFF_WDOG, 32'h0);
        chk(32'(rd !== 32'h0), 32'h1, "watchdog idle");
        wr(ciecd_pkg::OFF_STATUS, 32'h0);
        wr(ciecd_pkg::OFF_CMD, {29'h0, ciecd_pkg::OP_KICK});
        rdc(ciecd_pkg::OFF_WDOG, 32'h0, "watchdog cleared");
        xfer(1'h0, ciecd_pkg::OFF_PRESC, 32'h0);
        chk(32'(rd < 32'h10), 32'h1, "prescaler restart");
        rdc(ciecd_pkg::OFF_STATUS, 32'h6, "kick status");
        // indirect call, then a second one after its checks and a status clear
        wr(ciecd_pkg::OFF_ACC, 32'h34);
        wr(ciecd_pkg::OFF_UPC, 32'h5a);
        wr(ciecd_pkg::OFF_PC, 32'h123);
        wr(ciecd_pkg::OFF_STATUS, 32'h7);
        wr(ciecd_pkg::OFF_CMD, {29'h0, ciecd_pkg::OP_ICALL});
        xfer(1'h0, ciecd_pkg::OFF_STACK, 32'h0);
        chk(32'(waits), 32'h2, "call cycles");
        chk(rd, 32'h124, "return push");
        rdc(ciecd_pkg::OFF_PC, 32'h5a34, "call target");
        rdc(ciecd_pkg::OFF_STATUS, 32'h7, "call flags");
        wr(ciecd_pkg::OFF_STATUS, 32'h0);
        wr(ciecd_pkg::OFF_CMD, {29'h0, ciecd_pkg::OP_ICALL});
        rdc(ciecd_pkg::OFF_STACK, 32'h5a35, "second push");
        rdc(ciecd_pkg::OFF_STATUS, 32'h0, "call flags low");
        // refused and read-only places
        xfer(1'h0, 12'h100, 32'h0);
        chk(rd, 32'h0, "unmapped data");
        chk({31'h0, er}, 32'h1, "unmapped error");
        xfer(1'h0, 12'h201, 32'h0);
        chk({31'h0, er}, 32'h1, "misaligned error");
        xfer(1'h1, ciecd_pkg::OFF_STACK, 32'h7fff);
        chk({31'h0, er}, 32'h0, "read-only no error");
        rdc(ciecd_pkg::OFF_STACK, 32'h5a35, "read-only kept");
        // second reset in mid-run
        wr(ciecd_pkg::OFF_ACC, 32'h77);
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        rdc(ciecd_pkg::OFF_ACC, 32'h0, "acc second reset");
        rdc(ciecd_pkg::OFF_STATUS, 32'h6, "status second reset");
        end_sim();
    end

endmodule : ciecd_exec_tb
